// ### cwp_pkg.sv
// Shared constants and carrier types for the configuration write-protect block
package cwp_pkg;

  // Register bus geometry
  localparam int ADDR_W = 5;
  localparam int RDATA_W = 24;

  // Register addresses
  localparam logic [4:0] ADDR_CUR_SAMPLE = 5'h00;
  localparam logic [4:0] ADDR_V1_SAMPLE = 5'h01;
  localparam logic [4:0] ADDR_V2_SAMPLE = 5'h02;
  localparam logic [4:0] ADDR_MAIN_CFG = 5'h08;
  localparam logic [4:0] ADDR_INTF_CTRL = 5'h09;
  localparam logic [4:0] ADDR_WRITE_LOCK_KEY = 5'h0A;
  localparam logic [4:0] ADDR_SYNC_CAPTURE = 5'h0B;
  localparam logic [4:0] ADDR_SYNC_COUNT_LOW = 5'h0C;
  localparam logic [4:0] ADDR_SYNC_COUNT_HIGH = 5'h0D;
  localparam logic [4:0] ADDR_TEMP_OFFSET = 5'h10;
  localparam logic [4:0] ADDR_CHECKSUM = 5'h11;
  localparam logic [4:0] ADDR_FLAGS_A = 5'h12;
  localparam logic [4:0] ADDR_FLAGS_B = 5'h13;
  localparam logic [4:0] ADDR_FLAGS_AB = 5'h14;

  // Lock keys
  localparam logic [7:0] KEY_LOCK = 8'hCA;
  localparam logic [7:0] KEY_UNLOCK = 8'h9C;

  // Field positions
  localparam int RATE_LSB = 4;
  localparam int SOFT_RESET_BIT = 6;
  localparam int FA_RESET_ON_BIT = 0;
  localparam int FA_CRC_CHANGE_BIT = 1;
  localparam int FA_PROT_BIT = 2;
  localparam int FB_MISSED_BIT = 3;
  localparam int FB_RSVD_BIT = 7;

  // Reset values of writable registers
  localparam logic [7:0] MAIN_CFG_RST = 8'h00;
  localparam logic [7:0] INTF_CTRL_RST = 8'h00;

  // CRC engine
  localparam int CRC_STEPS = 64;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;

  // Timing counts in input clock cycles
  localparam int DIV_W = 13;
  localparam logic [DIV_W-1:0] DIV_BASE = 13'h0200;
  localparam int RESET_CYCLES = 128;
  localparam int RST_CNT_W = 8;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } cwp_req_t;

  typedef struct packed {
    logic [23:0] cur;
    logic [23:0] v1;
    logic [23:0] v2;
  } cwp_samples_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [15:0] lfsr;
    logic [CRC_STEPS-1:0] bits;
  } cwp_crc_state_t;

  typedef struct packed {
    logic [7:0] main_cfg;
    logic [7:0] intf_ctrl;
    logic [7:0] sync_capture;
    logic [7:0] sync_count_low;
    logic [7:0] sync_count_high;
    logic [7:0] temp_offset_trim;
    logic [15:0] checksum;
    cwp_samples_t samples;
    logic locked;
    logic reset_on;
    logic crc_change_flag;
    logic protection_active_flag;
    logic data_missed_flag;
    logic [2:0] rd_seen;
    logic [DIV_W-1:0] div_cnt;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic crc_start;
    logic cycle_tick;
    logic rd_valid;
    logic [RDATA_W-1:0] rd_data;
  } cwp_state_t;

  localparam cwp_state_t CWP_STATE_RST = '{
    main_cfg: MAIN_CFG_RST,
    intf_ctrl: INTF_CTRL_RST,
    reset_on: 1'b1,
    rst_cnt: 8'(RESET_CYCLES - 1),
    default: '0
  };

endpackage

// ### cwp_crc16.sv
// Serial CRC-16 engine, one input bit per clock
`timescale 1ns/100ps
module cwp_crc16
  import cwp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [CRC_STEPS-1:0] i_bits,
  output logic o_done,
  output logic [15:0] o_crc
);

  cwp_crc_state_t st_reg;
  cwp_crc_state_t st_next;
  logic fb;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    fb = 1'b0;
    if (i_start) begin
      // A new start restarts any run in flight
      st_next.busy = 1'b1;
      st_next.cnt = '0;
      st_next.lfsr = CRC_PRESET;
      st_next.bits = i_bits;
    end else if (st_reg.busy) begin
      // Byte order low first, bits within a byte high first
      fb = st_reg.bits[{st_reg.cnt[5:3], ~st_reg.cnt[2:0]}] ^ st_reg.lfsr[15];
      st_next.lfsr = {st_reg.lfsr[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      st_next.cnt = st_reg.cnt + 6'h01;
      if (st_reg.cnt == 6'(CRC_STEPS - 1)) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_done = st_reg.done;
  assign o_crc = st_reg.lfsr;

  chk_crc_run_length: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_start |-> ##65 o_done)
    else $error("CRC run did not finish after 64 steps");

  chk_crc_preset_ones: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_start |=> (o_crc == 16'hFFFF) && !o_done)
    else $error("CRC state not preset to all ones");

endmodule

// ### cwp_cfg_protect.sv
// Configuration write protection, configuration CRC and status flags
`timescale 1ns/100ps
// Summary of operation
// - Protection off after any reset
// - Locked: configuration writes are ignored
// - Reads always answered, locked or not
// - Key 0xCA to lock register locks
// - Key 0x9C to lock register unlocks
// - Internal configuration stays at defaults
// - Per output cycle CRC over configuration
// - 64 bits, low byte first, MSB first
// - CRC state preset to all ones
// - Feedback LFSR, 64 steps, store result
// - Checksum default follows factory temperature trim
// - Checksum change sets flag A bit 1
// - Reading flags A clears CRC flag
// - Lock sets A bit 2, cycle sets it again while locked
// - Reset-in-progress clears when reset ends
// - Unread samples in cycle set B bit 3
// - Both status registers readable in one read
// - Polynomial x16 + x12 + x5 + 1
// - Output cycle is clock over 512..4096
module cwp_cfg_protect
  import cwp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_temp_trim,
  input wire cwp_samples_t i_samples,
  input wire cwp_req_t i_req,
  output logic o_rd_valid,
  output logic [RDATA_W-1:0] o_rd_data,
  output logic o_locked,
  output logic o_cycle_tick,
  output logic [7:0] o_flags_a,
  output logic [15:0] o_checksum
);

  cwp_state_t st_reg;
  cwp_state_t st_next;

  logic crc_done;
  logic [15:0] crc_val;
  logic [CRC_STEPS-1:0] crc_bits;
  logic [7:0] flags_a;
  logic [7:0] flags_b;
  logic [1:0] rate_sel;
  logic [DIV_W-1:0] div_last;
  logic tick;
  logic soft_reset;
  logic crc_rst;

  // Status register images
  always_comb begin
    flags_a = 8'h00;
    flags_a[FA_RESET_ON_BIT] = st_reg.reset_on;
    flags_a[FA_CRC_CHANGE_BIT] = st_reg.crc_change_flag;
    flags_a[FA_PROT_BIT] = st_reg.protection_active_flag;
    flags_b = 8'h00;
    flags_b[FB_MISSED_BIT] = st_reg.data_missed_flag;
    flags_b[FB_RSVD_BIT] = 1'b0;
  end

  // Covered bytes: config, interference control, trim, flag A bit 2, flag B bit 7
  always_comb begin
    crc_bits = '0;
    crc_bits[7:0] = st_reg.main_cfg;
    crc_bits[15:8] = st_reg.intf_ctrl;
    crc_bits[23:16] = st_reg.temp_offset_trim;
    crc_bits[24 + FA_PROT_BIT] = flags_a[FA_PROT_BIT];
    crc_bits[32 + FB_RSVD_BIT] = flags_b[FB_RSVD_BIT];
  end

  // Output cycle period from the sample-rate field
  always_comb begin
    rate_sel = st_reg.main_cfg[RATE_LSB +: 2];
    div_last = (DIV_BASE << rate_sel) - 13'h0001;
  end

  // Soft reset also abandons a checksum run in flight
  assign crc_rst = i_sys_rst || soft_reset;

  cwp_crc16 u_crc (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(crc_rst),
    .i_start(st_reg.crc_start),
    .i_bits(crc_bits),
    .o_done(crc_done),
    .o_crc(crc_val)
  );

  always_comb begin
    st_next = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.crc_start = 1'b0;
    st_next.cycle_tick = 1'b0;
    tick = 1'b0;
    soft_reset = 1'b0;

    // Reset period, then free-running output cycle divider
    if (st_reg.reset_on) begin
      // Trim is captured every cycle of the reset period, held after it
      st_next.temp_offset_trim = i_temp_trim;
      if (st_reg.rst_cnt == 8'(RESET_CYCLES - 2)) begin
        st_next.crc_start = 1'b1;
      end
      if (st_reg.rst_cnt == '0) begin
        st_next.reset_on = 1'b0;
      end else begin
        st_next.rst_cnt = st_reg.rst_cnt - 8'h01;
      end
    end else if (st_reg.div_cnt >= div_last) begin
      // Compare by >= so a rate change to a shorter period cannot overrun
      st_next.div_cnt = '0;
      tick = 1'b1;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 13'h0001;
    end

    // Reads: clears first so that same-cycle events below win
    if (i_req.rd) begin
      st_next.rd_valid = 1'b1;
      case (i_req.addr)
        ADDR_CUR_SAMPLE: begin
          st_next.rd_data = st_reg.samples.cur;
          st_next.rd_seen[0] = 1'b1;
        end
        ADDR_V1_SAMPLE: begin
          st_next.rd_data = st_reg.samples.v1;
          st_next.rd_seen[1] = 1'b1;
        end
        ADDR_V2_SAMPLE: begin
          st_next.rd_data = st_reg.samples.v2;
          st_next.rd_seen[2] = 1'b1;
        end
        ADDR_MAIN_CFG: st_next.rd_data = {16'h0000, st_reg.main_cfg};
        ADDR_INTF_CTRL: st_next.rd_data = {16'h0000, st_reg.intf_ctrl};
        ADDR_SYNC_CAPTURE: st_next.rd_data = {16'h0000, st_reg.sync_capture};
        ADDR_SYNC_COUNT_LOW: st_next.rd_data = {16'h0000, st_reg.sync_count_low};
        ADDR_SYNC_COUNT_HIGH: st_next.rd_data = {16'h0000, st_reg.sync_count_high};
        ADDR_TEMP_OFFSET: st_next.rd_data = {16'h0000, st_reg.temp_offset_trim};
        ADDR_CHECKSUM: st_next.rd_data = {8'h00, st_reg.checksum};
        ADDR_FLAGS_A: begin
          st_next.rd_data = {16'h0000, flags_a};
          st_next.crc_change_flag = 1'b0;
          st_next.protection_active_flag = 1'b0;
        end
        ADDR_FLAGS_B: begin
          st_next.rd_data = {16'h0000, flags_b};
          st_next.data_missed_flag = 1'b0;
        end
        ADDR_FLAGS_AB: begin
          st_next.rd_data = {8'h00, flags_b, flags_a};
          st_next.crc_change_flag = 1'b0;
          st_next.protection_active_flag = 1'b0;
          st_next.data_missed_flag = 1'b0;
        end
        default: st_next.rd_data = '0;
      endcase
    end

    // Writes: the lock register is always open, the rest only while unlocked
    if (i_req.wr) begin
      if (i_req.addr == ADDR_WRITE_LOCK_KEY) begin
        if (i_req.wdata == KEY_LOCK) begin
          st_next.locked = 1'b1;
          st_next.protection_active_flag = 1'b1;
        end else if (i_req.wdata == KEY_UNLOCK) begin
          st_next.locked = 1'b0;
          st_next.protection_active_flag = 1'b0;
        end
        // Any other value leaves the lock as it is
      end else if (!st_reg.locked) begin
        case (i_req.addr)
          ADDR_MAIN_CFG: begin
            st_next.main_cfg = i_req.wdata;
            st_next.main_cfg[SOFT_RESET_BIT] = 1'b0;
            soft_reset = i_req.wdata[SOFT_RESET_BIT];
          end
          ADDR_INTF_CTRL: st_next.intf_ctrl = i_req.wdata;
          ADDR_SYNC_CAPTURE: st_next.sync_capture = i_req.wdata;
          ADDR_SYNC_COUNT_LOW: st_next.sync_count_low = i_req.wdata;
          ADDR_SYNC_COUNT_HIGH: st_next.sync_count_high = i_req.wdata;
          // Internal and read-only locations have no write path
          default: st_next.rd_seen = st_next.rd_seen;
        endcase
      end
    end

    // Output cycle events
    if (tick) begin
      st_next.cycle_tick = 1'b1;
      st_next.samples = i_samples;
      st_next.crc_start = 1'b1;
      st_next.rd_seen = 3'b000;
      if (st_reg.rd_seen != 3'b111) begin
        st_next.data_missed_flag = 1'b1;
      end
      if (st_reg.locked) begin
        st_next.protection_active_flag = 1'b1;
      end
    end

    // New checksum; the load inside the reset period is the silent default
    if (crc_done) begin
      st_next.checksum = crc_val;
      if (!st_reg.reset_on && crc_val != st_reg.checksum) begin
        st_next.crc_change_flag = 1'b1;
      end
    end

    // Software reset restarts the whole block, protection included
    if (soft_reset) begin
      st_next = CWP_STATE_RST;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_reg <= CWP_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rd_valid = st_reg.rd_valid;
  assign o_rd_data = st_reg.rd_data;
  assign o_locked = st_reg.locked;
  assign o_cycle_tick = st_reg.cycle_tick;
  assign o_flags_a = {5'b00000, st_reg.protection_active_flag, st_reg.crc_change_flag, st_reg.reset_on};
  assign o_checksum = st_reg.checksum;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);

  chk_reset_unlocked: assert property ($fell(i_sys_rst) |-> !o_locked && o_flags_a[0])
    else $error("Protection not off after reset");

  chk_locked_write_ignored: assert property (
    o_locked && i_req.wr && i_req.addr != ADDR_WRITE_LOCK_KEY
    |=> $stable(st_reg.main_cfg) && $stable(st_reg.intf_ctrl) && $stable(st_reg.sync_capture))
    else $error("Configuration changed while locked");

  chk_read_answered: assert property (i_req.rd |=> o_rd_valid)
    else $error("Read not answered");

  chk_lock_key: assert property (
    i_req.wr && i_req.addr == ADDR_WRITE_LOCK_KEY && i_req.wdata == KEY_LOCK |=> o_locked && o_flags_a[2])
    else $error("Lock key did not lock");

  chk_unlock_key: assert property (
    i_req.wr && i_req.addr == ADDR_WRITE_LOCK_KEY && i_req.wdata == KEY_UNLOCK |=> !o_locked)
    else $error("Unlock key did not unlock");

  chk_other_key_kept: assert property (
    i_req.wr && i_req.addr == ADDR_WRITE_LOCK_KEY && i_req.wdata != KEY_LOCK && i_req.wdata != KEY_UNLOCK
    |=> o_locked == $past(o_locked))
    else $error("Lock state changed by a non-key value");

  chk_crc_change_set: assert property (
    crc_done && !st_reg.reset_on && crc_val != o_checksum |=> o_flags_a[1] && o_checksum == $past(crc_val))
    else $error("Checksum change not flagged");

  chk_flags_a_read_clear: assert property (
    i_req.rd && i_req.addr == ADDR_FLAGS_A && !crc_done && !tick ##1 !i_req.wr |-> !o_flags_a[1])
    else $error("CRC flag not cleared by read");

  chk_prot_reassert: assert property (o_locked && tick |=> o_flags_a[2] && o_cycle_tick)
    else $error("Protection flag not set at output cycle");

  chk_reset_period_end: assert property (
    st_reg.reset_on && st_reg.rst_cnt == '0 && !soft_reset |=> !o_flags_a[0])
    else $error("Reset flag not cleared at end of reset period");

  chk_missed_set: assert property (tick && st_reg.rd_seen != 3'b111 |=> st_reg.data_missed_flag)
    else $error("Missed data not flagged");

  chk_cycle_period: assert property (o_cycle_tick && $stable(rate_sel) |-> st_reg.div_cnt == '0)
    else $error("Output cycle divider not restarted");

  chk_read_ignores_lock: assert property (
    o_locked && i_req.rd && i_req.addr == ADDR_MAIN_CFG |=> o_rd_data == {16'h0000, $past(st_reg.main_cfg)})
    else $error("Configuration read wrong while locked");

  chk_status_read_data: assert property (
    i_req.rd && i_req.addr == ADDR_FLAGS_A |=> o_rd_data == {16'h0000, $past(flags_a)})
    else $error("Status A read data wrong");

  chk_prot_read_clear: assert property (
    i_req.rd && i_req.addr == ADDR_FLAGS_A && !tick |=> !o_flags_a[2])
    else $error("Protection flag not cleared by read");

  chk_missed_read_clear: assert property (
    i_req.rd && i_req.addr == ADDR_FLAGS_B && !tick |=> !st_reg.data_missed_flag)
    else $error("Missed data flag not cleared by read");

  chk_combined_read: assert property (
    i_req.rd && i_req.addr == ADDR_FLAGS_AB |=> o_rd_data[15:0] == {$past(flags_b), $past(flags_a)})
    else $error("Combined status read wrong");

  chk_unlock_clears_prot: assert property (
    i_req.wr && i_req.addr == ADDR_WRITE_LOCK_KEY && i_req.wdata == KEY_UNLOCK && !tick |=> !o_flags_a[2])
    else $error("Unlock left protection flag set");

  chk_lock_held_idle: assert property (
    !(i_req.wr && i_req.addr == ADDR_WRITE_LOCK_KEY) |=> $stable(o_locked))
    else $error("Lock state changed without a key write");

  chk_other_addr_ignored: assert property (
    i_req.wr && i_req.addr > ADDR_SYNC_COUNT_HIGH |=> $stable(st_reg.main_cfg) && $stable(st_reg.intf_ctrl))
    else $error("Write to internal location changed configuration");

  chk_no_reset_tick: assert property (
    st_reg.reset_on |-> !tick)
    else $error("Output cycle during reset period");

  // Soft reset is left out where it reloads every field
  chk_sample_capture: assert property (
    tick && !soft_reset |=> st_reg.samples == $past(i_samples) && st_reg.rd_seen == 3'b000)
    else $error("Samples not captured at output cycle");

  chk_tick_starts_crc: assert property (
    tick && !soft_reset |=> st_reg.crc_start)
    else $error("Output cycle did not start checksum");

  chk_checksum_on_done: assert property (
    !crc_done && !soft_reset |=> $stable(o_checksum))
    else $error("Checksum changed without a finished run");

  chk_trim_capture: assert property (
    st_reg.reset_on && !soft_reset |=> st_reg.temp_offset_trim == $past(i_temp_trim))
    else $error("Trim not captured during reset period");

  chk_trim_held: assert property (
    !st_reg.reset_on && !soft_reset |=> $stable(st_reg.temp_offset_trim))
    else $error("Trim changed outside reset period");

  chk_soft_reset_restart: assert property (
    soft_reset |=> !o_locked && o_flags_a == 8'h01 && !o_cycle_tick)
    else $error("Soft reset did not restart the block");

endmodule

// ### cwp_host.sv
// Host model issuing register strobes the way the serial master would
`timescale 1ns/100ps
module cwp_host
  import cwp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rd_valid,
  input wire logic [RDATA_W-1:0] i_rd_data,
  output cwp_req_t o_req
);
  initial o_req = '0;

  // Idle fields scrambled so stale values never look valid
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge i_clk_sys);
    o_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic bus_rd(input logic [4:0] a, output logic v, output logic [RDATA_W-1:0] q);
    @(posedge i_clk_sys);
    o_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge i_clk_sys);
    o_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
    #1;
    v = i_rd_valid;
    q = i_rd_data;
  endtask

  // Later changes go unlock, write, lock
  task automatic cfg_change(input logic [4:0] a, input logic [7:0] d);
    bus_wr(ADDR_WRITE_LOCK_KEY, KEY_UNLOCK);
    bus_wr(a, d);
    bus_wr(ADDR_WRITE_LOCK_KEY, KEY_LOCK);
  endtask
endmodule

// ### config_write_protect_crc_status_bench.sv
// Self-checking bench for write protection, configuration checksum and status flags
`timescale 1ns/100ps
module config_write_protect_crc_status_bench
  import cwp_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] trim;
  cwp_samples_t samp;
  cwp_req_t req;
  logic rd_valid, locked, tick, v;
  logic [RDATA_W-1:0] rd_data, q;
  logic [7:0] flags_a, m, x;
  logic [15:0] csum;
  int failures = 0;
  int n_tests = 0;
  int seed = 59;
  int cycles = 0;
  int per;

  cwp_cfg_protect u_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_temp_trim(trim), .i_samples(samp),
    .i_req(req), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_locked(locked),
    .o_cycle_tick(tick), .o_flags_a(flags_a), .o_checksum(csum));
  cwp_host u_host (.i_clk_sys(clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_req(req));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Run length is about 18k cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  end

  task automatic check_val(input logic [23:0] got, input logic [23:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [23:0] exp);
    u_host.bus_rd(a, v, q);
    check_bit(v, 1'b1, "read answered");
    check_val(q, exp, "read data");
  endtask

  // Returns the cycle count since the call, so back-to-back calls give the period
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 9000);
    if (n >= 9000) begin
      failures++;
      $display("[FAIL] %0t no output cycle", $time);
    end
  endtask

  function automatic logic [15:0] crc_calc(input logic [7:0] mc, input logic [7:0] ic, input logic [7:0] t,
                                           input logic p);
    logic [63:0] d;
    logic [15:0] b;
    logic fb;
    d = {32'h0000_0000, 5'h00, p, 2'h0, t, ic, mc};
    b = 16'hFFFF;
    for (int k = 0; k < 8; k++) begin
      for (int n = 7; n >= 0; n--) begin
        fb = d[k*8+n] ^ b[15];
        b = {b[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
      end
    end
    return b;
  endfunction

  initial begin
    trim = 8'($random(seed));
    samp = 72'({$random(seed), $random(seed), $random(seed)});
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check_bit(locked, 1'b0, "unlocked after reset");
    check_val(flags_a, 8'h01, "flags A in reset");
    repeat (130) @(posedge clk);
    #1;
    check_bit(flags_a[0], 1'b0, "reset period over");
    check_val(csum, crc_calc(8'h00, 8'h00, trim, 1'b0), "default checksum");
    m = 8'($random(seed)) & 8'h8F;
    x = 8'($random(seed));
    u_host.bus_wr(ADDR_MAIN_CFG, m);
    u_host.bus_wr(ADDR_INTF_CTRL, x);
    rd_chk(ADDR_MAIN_CFG, {16'h0000, m});
    rd_chk(ADDR_INTF_CTRL, {16'h0000, x});
    u_host.bus_wr(5'h1F, 8'hA5);
    rd_chk(5'h1F, 24'h000000);
    u_host.bus_wr(ADDR_WRITE_LOCK_KEY, 8'($random(seed)) | 8'h01);
    #1;
    check_bit(locked, 1'b0, "stray key ignored");
    wait_tick(per);
    repeat (70) @(posedge clk);
    #1;
    check_val(csum, crc_calc(m, x, trim, 1'b0), "checksum");
    u_host.bus_rd(ADDR_FLAGS_A, v, q);
    check_bit(q[1], 1'b1, "checksum change flag");
    check_bit(flags_a[1], 1'b0, "change flag cleared");
    u_host.bus_wr(ADDR_WRITE_LOCK_KEY, KEY_LOCK);
    #1;
    check_bit(locked, 1'b1, "locked");
    check_bit(flags_a[2], 1'b1, "protection flag");
    u_host.bus_wr(ADDR_WRITE_LOCK_KEY, 8'($random(seed)) | 8'h01);
    #1;
    check_bit(locked, 1'b1, "stray key ignored");
    u_host.bus_wr(ADDR_MAIN_CFG, ~m & 8'h8F);
    u_host.bus_wr(ADDR_INTF_CTRL, ~x);
    rd_chk(ADDR_MAIN_CFG, {16'h0000, m});
    rd_chk(ADDR_INTF_CTRL, {16'h0000, x});
    u_host.bus_rd(ADDR_FLAGS_A, v, q);
    check_bit(flags_a[2], 1'b0, "protection flag read clear");
    wait_tick(per);
    check_bit(flags_a[2], 1'b1, "protection flag back");
    repeat (70) @(posedge clk);
    #1;
    check_val(csum, crc_calc(m, x, trim, 1'b1), "locked checksum");
    u_host.bus_rd(ADDR_FLAGS_AB, v, q);
    check_val(q[7:0], 8'h06, "combined A");
    check_bit(q[11], 1'b1, "combined B missed");
    @(posedge clk);
    samp <= 72'({$random(seed), $random(seed), $random(seed)});
    wait_tick(per);
    rd_chk(ADDR_CUR_SAMPLE, samp.cur);
    rd_chk(ADDR_V1_SAMPLE, samp.v1);
    rd_chk(ADDR_V2_SAMPLE, samp.v2);
    u_host.bus_rd(ADDR_FLAGS_B, v, q);
    check_bit(q[3], 1'b1, "missed before sample reads");
    wait_tick(per);
    u_host.bus_rd(ADDR_FLAGS_B, v, q);
    check_bit(q[3], 1'b0, "all read, no miss");
    wait_tick(per);
    u_host.bus_rd(ADDR_FLAGS_B, v, q);
    check_bit(q[3], 1'b1, "missed set");
    u_host.bus_rd(ADDR_FLAGS_B, v, q);
    check_bit(q[3], 1'b0, "missed read clear");
    u_host.cfg_change(ADDR_INTF_CTRL, ~x);
    #1;
    check_bit(locked, 1'b1, "relocked");
    rd_chk(ADDR_INTF_CTRL, {16'h0000, ~x});
    u_host.bus_wr(ADDR_WRITE_LOCK_KEY, KEY_UNLOCK);
    #1;
    check_bit(locked, 1'b0, "unlocked");
    for (int r = 0; r < 4; r++) begin
      u_host.bus_wr(ADDR_MAIN_CFG, {2'b00, 2'(r), 4'h0});
      wait_tick(per);
      wait_tick(per);
      check_val(24'(per), 24'(512 << r), "output cycle period");
    end
    u_host.bus_wr(ADDR_MAIN_CFG, 8'h40);
    #1;
    check_val(flags_a, 8'h01, "soft reset flags");
    repeat (130) @(posedge clk);
    #1;
    check_bit(flags_a[0], 1'b0, "soft reset over");
    rd_chk(ADDR_MAIN_CFG, 24'h000000);
    check_val(csum, crc_calc(8'h00, 8'h00, trim, 1'b0), "default checksum after soft reset");
    u_host.bus_wr(ADDR_WRITE_LOCK_KEY, KEY_LOCK);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check_bit(locked, 1'b0, "unlocked after second reset");
    check_val(flags_a, 8'h01, "flags A after second reset");
    tally_and_finish();
  end
endmodule
